// >>> rtl/plss_pkg.sv
package plss_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PLSS_OFF_LINK_STATE = 8'hf0;
	localparam logic [7:0] PLSS_OFF_SLOT_FEAT = 8'hf4;
	localparam logic [7:0] PLSS_OFF_IRQ_STATUS = 8'hf8;
	localparam logic [7:0] PLSS_OFF_IRQ_ENABLE = 8'hfc;
	localparam logic [7:0] PLSS_OFF_IRQ_CLEAR = 8'he8;
	localparam logic [7:0] PLSS_OFF_OVERRIDE = 8'hec;
	// ----------------------------------------------------------------
	// link state report fields
	// ----------------------------------------------------------------
	localparam int PLSS_LS_SPEED_LSB = 16;
	localparam int PLSS_LS_WIDTH_LSB = 20;
	localparam int PLSS_LS_TRAIN_ERR = 26;
	localparam int PLSS_LS_TRAINING = 27;
	localparam int PLSS_LS_SLOT_CLK = 28;
	localparam int PLSS_LS_DL_ACTIVE = 29;
	localparam logic [3:0] PLSS_SPEED_2G5 = 4'h1;
	localparam logic [5:0] PLSS_WIDTH_X1 = 6'h01;
	// ----------------------------------------------------------------
	// slot feature report fields
	// ----------------------------------------------------------------
	localparam int PLSS_SF_ATTN_BTN = 0;
	localparam int PLSS_SF_PWR_CTRL = 1;
	localparam int PLSS_SF_ATTN_IND = 3;
	localparam int PLSS_SF_PWR_IND = 4;
	localparam int PLSS_SF_SURPRISE = 5;
	localparam int PLSS_SF_HP_CAP = 6;
	localparam int PLSS_SF_PLV_LSB = 7;
	localparam int PLSS_SF_PLS_LSB = 15;
	localparam int PLSS_SF_SLOTNUM_LSB = 19;
	localparam logic [7:0] PLSS_PLV_RESET = 8'h00;
	localparam logic [1:0] PLSS_PLS_RESET = 2'h0;
	localparam logic [12:0] PLSS_SLOTNUM_RESET = 13'h0000;
	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int PLSS_IRQ_TRAIN_ERR = 0;
	localparam int PLSS_IRQ_DL_CHANGE = 1;
	localparam int PLSS_IRQ_PWR_MSG = 2;
	localparam int PLSS_IRQ_N = 3;
endpackage : plss_pkg

// >>> rtl/plss_regs.sv
`timescale 1ns/1ps

// Functional notes
// RQ1: link speed field 19:16 always reads 0001b, meaning 2.5 Gb/s.
// RQ2: bits 25:20 report negotiated lane width, single lane x1.
// RQ3: bit 26 sets on training failure, clears on reaching L0, resets zero.
// RQ4: bit 27 reads one during link training, zero after, resets zero.
// RQ5: bit 28 shows slot clock choice, one means platform reference clock.
// RQ6: slot clock default overridable by strap, SMBus or EEPROM load.
// RQ7: bit 29 reads one only while data link machine is DL_Active.
// RQ8: slot capabilities word and power limit only exist on downstream ports.
// RQ9: slot bit 0 shows attention button present, resets zero.
// RQ10: slot bit 1 shows power controller present, resets zero.
// RQ11: slot bit 3 shows attention indicator present, resets zero.
// RQ12: slot bit 4 shows power indicator present, resets zero.
// RQ13: slot bit 5 shows card may be removed without notice, resets zero.
// RQ14: slot bit 6 shows hot-plug capable, default from strap or EEPROM.
// RQ15: bits 14:7 power limit value, reset 00h, writes send power message.
// RQ16: bits 16:15 power limit scale, reset 00b, writes send power message.
// RQ17: bits 31:19 report physical slot number, resets zero.
// RQ18: other slot capability defaults replaceable by SMBus or EEPROM load.
// RQ19: each write touching power limit fields gives exactly one message request.
module plss_regs
	import plss_pkg::*;
#(
	parameter bit DOWNSTREAM = 1'b1
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// link state inputs
	input wire logic train_fail_i,
	input wire logic train_active_i,
	input wire logic link_in_l0_i,
	input wire logic dl_active_i,
	// straps and default loader (SMBus / EEPROM)
	input wire logic strap_slot_clk_i,
	input wire logic strap_hp_cap_i,
	input wire logic ld_valid_i,
	input wire logic [31:0] ld_slot_feat_i,
	input wire logic ld_slot_clk_i,
	input wire logic ld_slot_clk_we_i,
	// power limit message to transaction layer
	output logic pwr_msg_req_o,
	output logic [7:0] pwr_msg_value_o,
	output logic [1:0] pwr_msg_scale_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic train_err;
	logic training;
	logic dl_active;
	logic slot_clk;
	logic [5:0] slot_caps;
	logic hp_cap;
	logic [7:0] plv;
	logic [1:0] pls;
	logic [12:0] slot_num;
	logic [PLSS_IRQ_N-1:0] irq_status;
	logic [PLSS_IRQ_N-1:0] irq_enable;
	logic ack;
	logic [31:0] rdata;
	logic strap_seen;
	logic dl_active_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
	wire wr_req = bus_req & wb_we_i;
	wire sel_ls = (wb_adr_i == PLSS_OFF_LINK_STATE);
	wire sel_sf = (wb_adr_i == PLSS_OFF_SLOT_FEAT) & DOWNSTREAM; // RQ8
	wire sel_st = (wb_adr_i == PLSS_OFF_IRQ_STATUS);
	wire sel_en = (wb_adr_i == PLSS_OFF_IRQ_ENABLE);
	wire sel_clr = (wb_adr_i == PLSS_OFF_IRQ_CLEAR);
	wire sel_ovr = (wb_adr_i == PLSS_OFF_OVERRIDE);
	wire wr_plv = wr_req & sel_sf & wb_sel_i[0] & wb_sel_i[1]; // RQ15
	wire wr_pls = wr_req & sel_sf & (wb_sel_i[1] | wb_sel_i[2]); // RQ16
	wire pwr_write = wr_req & sel_sf & (wb_sel_i[0] | wb_sel_i[1] | wb_sel_i[2]); // RQ19
	wire [7:0] next_plv = wb_dat_i[PLSS_SF_PLV_LSB +: 8];
	wire [1:0] next_pls = wb_dat_i[PLSS_SF_PLS_LSB +: 2];

	// ----------------------------------------------------------------
	// read assembly
	// ----------------------------------------------------------------
	wire [31:0] ls_word = {2'b00, dl_active, slot_clk, training, train_err, PLSS_WIDTH_X1, // RQ2
		PLSS_SPEED_2G5, 16'h0000}; // RQ1
	wire [31:0] sf_word = {slot_num, 2'b00, pls, plv, hp_cap, slot_caps[5:3], 1'b0, slot_caps[1:0]}; // RQ17
	wire [31:0] next_rdata = sel_ls ? ls_word :
		sel_sf ? sf_word :
		sel_st ? {29'h0000_0000, irq_status} :
		sel_en ? {29'h0000_0000, irq_enable} :
		32'h0000_0000;

	// event sources for the interrupt status
	wire dl_change = dl_active ^ dl_active_q;
	wire [PLSS_IRQ_N-1:0] irq_set = {pwr_write, dl_change, train_fail_i};
	wire [PLSS_IRQ_N-1:0] irq_clr = (wr_req & sel_clr & wb_sel_i[0]) ? wb_dat_i[PLSS_IRQ_N-1:0] :
		{PLSS_IRQ_N{1'b0}};

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;
	assign pwr_msg_value_o = plv;
	assign pwr_msg_scale_o = pls;
	assign irq_o = |(irq_status & irq_enable);

	// ----------------------------------------------------------------
	// bus handshake: ack one cycle after request, dropped next cycle
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
		end else if (ce_i) begin
			ack <= bus_req;
			rdata <= next_rdata;
		end
	end

	// training and data link status tracking
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			train_err <= 1'b0;
			training <= 1'b0;
			dl_active <= 1'b0;
			dl_active_q <= 1'b0;
		end else if (ce_i) begin
			if (train_fail_i) begin
				train_err <= 1'b1; // RQ3
			end else if (link_in_l0_i) begin
				train_err <= 1'b0; // RQ3
			end
			training <= train_active_i; // RQ4
			dl_active <= dl_active_i; // RQ7
			dl_active_q <= dl_active;
		end
	end

	// strap capture after reset release, then loader overrides
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			strap_seen <= 1'b0;
			slot_clk <= 1'b0;
			hp_cap <= 1'b0;
			slot_caps <= 6'h00;
			slot_num <= PLSS_SLOTNUM_RESET;
		end else if (ce_i) begin
			if (!strap_seen) begin
				strap_seen <= 1'b1;
				slot_clk <= strap_slot_clk_i; // RQ5 RQ6
				hp_cap <= strap_hp_cap_i & DOWNSTREAM; // RQ14
			end else begin
				if (ld_slot_clk_we_i) begin
					slot_clk <= ld_slot_clk_i; // RQ6
				end
				if (ld_valid_i && DOWNSTREAM) begin
					slot_caps <= ld_slot_feat_i[5:0]; // RQ9 RQ10 RQ11 RQ12 RQ13 RQ18
					hp_cap <= ld_slot_feat_i[PLSS_SF_HP_CAP]; // RQ14
					slot_num <= ld_slot_feat_i[PLSS_SF_SLOTNUM_LSB +: 13]; // RQ17 RQ18
				end
			end
		end
	end

	// power limit fields and message request pulse
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			plv <= PLSS_PLV_RESET;
			pls <= PLSS_PLS_RESET;
			pwr_msg_req_o <= 1'b0;
		end else if (ce_i) begin
			pwr_msg_req_o <= pwr_write; // RQ15 RQ16 RQ19
			if (ld_valid_i && DOWNSTREAM && strap_seen) begin
				plv <= ld_slot_feat_i[PLSS_SF_PLV_LSB +: 8]; // RQ18
				pls <= ld_slot_feat_i[PLSS_SF_PLS_LSB +: 2];
			end else begin
				if (wr_plv) begin
					plv <= next_plv; // RQ15
				end
				if (wr_pls) begin
					pls <= next_pls; // RQ16
				end
			end
		end
	end

	// interrupt status and enable; set beats clear
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			irq_status <= {PLSS_IRQ_N{1'b0}};
			irq_enable <= {PLSS_IRQ_N{1'b0}};
		end else if (ce_i) begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (wr_req && sel_en && wb_sel_i[0]) begin
				irq_enable <= wb_dat_i[PLSS_IRQ_N-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_speed_fixed: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ1
		(ls_word[PLSS_LS_SPEED_LSB +: 4] == 4'h1)) else $error("link speed not 2.5");
	a_width_x1: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ2
		(ls_word[PLSS_LS_WIDTH_LSB +: 6] == 6'h01)) else $error("width not x1");
	a_train_err_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ3
		(ce_i && train_fail_i) |=> train_err) else $error("training error not set");
	a_train_err_clr: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ3
		(ce_i && !train_fail_i && link_in_l0_i) |=> !train_err) else $error("training error not cleared");
	a_training_follow: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ4
		ce_i |=> (training == $past(train_active_i))) else $error("training bit stale");
	a_dl_mirror: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ7
		ce_i |=> (ls_word[PLSS_LS_DL_ACTIVE] == $past(dl_active_i))) else $error("dl active wrong");
	a_msg_once: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ19
		(ce_i && pwr_write) |=> (pwr_msg_req_o ##1 (!pwr_msg_req_o || !ce_i || $past(pwr_write))))
		else $error("power message not single");
	a_plv_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ15
		(ce_i && wr_plv && !ld_valid_i) |=> (plv == $past(next_plv))) else $error("limit value not written");
	a_pls_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ16
		(ce_i && wr_pls && !ld_valid_i) |=> (pls == $past(next_pls))) else $error("limit scale not written");
	a_upstream_hide: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ8
		!DOWNSTREAM |-> !pwr_write) else $error("slot word on upstream");
	a_ack_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && bus_req) |=> ack ##1 (!ack || !ce_i)) else $error("ack not one cycle");

	// ----------------------------------------------------------------
	// read path checks on the bus data output
	// ----------------------------------------------------------------

	// link state word as seen by software, fixed fields included
	a_speed_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ1
		(ce_i && bus_req && !wb_we_i && sel_ls) |=> (wb_dat_o[PLSS_LS_SPEED_LSB +: 4] == PLSS_SPEED_2G5))
		else $error("speed field read wrong");
	a_width_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ2
		(ce_i && bus_req && !wb_we_i && sel_ls) |=> (wb_dat_o[PLSS_LS_WIDTH_LSB +: 6] == PLSS_WIDTH_X1))
		else $error("width field read wrong");
	a_ls_reserved: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && bus_req && !wb_we_i && sel_ls) |=> (wb_dat_o[31:30] == 2'b00 && wb_dat_o[15:0] == 16'h0000))
		else $error("link state reserved bits set");

	// slot word reserved bits and upstream hiding
	a_sf_reserved: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && bus_req && !wb_we_i && sel_sf) |=> (wb_dat_o[2] == 1'b0 && wb_dat_o[18:17] == 2'b00))
		else $error("slot word reserved bits set");
	a_upstream_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ8
		(ce_i && bus_req && !wb_we_i && (wb_adr_i == PLSS_OFF_SLOT_FEAT) && !DOWNSTREAM) |=>
		(wb_dat_o == 32'h0000_0000)) else $error("slot word visible upstream");

	// unmapped addresses read back zero
	a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && bus_req && !wb_we_i && !(sel_ls || sel_sf || sel_st || sel_en)) |=>
		(wb_dat_o == 32'h0000_0000)) else $error("unmapped read not zero");

	// ack stays low when nothing is asked
	a_ack_idle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && !bus_req) |=> !ack)
		else $error("ack without request");

	// ----------------------------------------------------------------
	// link status tracking checks
	// ----------------------------------------------------------------

	// training error holds when neither event is present
	a_train_err_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ3
		(ce_i && !train_fail_i && !link_in_l0_i) |=> $stable(train_err))
		else $error("training error moved");
	a_training_clr: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ4
		(ce_i && !train_active_i) |=> !ls_word[PLSS_LS_TRAINING])
		else $error("training bit not cleared");
	a_dl_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ7
		(ce_i && !dl_active_i) |=> !ls_word[PLSS_LS_DL_ACTIVE])
		else $error("dl active bit stuck");

	// every state bit comes out of reset at zero
	a_reset_values: assert property (@(posedge mclk_i) // RQ3 RQ4 RQ7 RQ15 RQ16 RQ17
		$rose(rst_b_i) |-> (!train_err && !training && !dl_active && plv == PLSS_PLV_RESET &&
		pls == PLSS_PLS_RESET && slot_num == PLSS_SLOTNUM_RESET && !pwr_msg_req_o && !ack))
		else $error("state not cleared by reset");

	// ----------------------------------------------------------------
	// strap and loader checks
	// ----------------------------------------------------------------

	// straps land on the first enabled edge after reset
	a_strap_clk: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ5 RQ6
		(ce_i && !strap_seen) |=> (ls_word[PLSS_LS_SLOT_CLK] == $past(strap_slot_clk_i)))
		else $error("slot clock strap lost");
	a_strap_hp: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ14
		(ce_i && !strap_seen) |=> (sf_word[PLSS_SF_HP_CAP] == ($past(strap_hp_cap_i) && DOWNSTREAM)))
		else $error("hot-plug strap lost");

	// loader override of the slot clock bit
	a_slot_clk_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ6
		(ce_i && strap_seen && ld_slot_clk_we_i) |=> (slot_clk == $past(ld_slot_clk_i)))
		else $error("slot clock override lost");

	// one loader write sets all capability bits, checked bit by bit
	a_attn_btn_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ9
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=> (sf_word[PLSS_SF_ATTN_BTN] == $past(ld_slot_feat_i[0])))
		else $error("attention button bit not loaded");
	a_pwr_ctrl_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ10
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=> (sf_word[PLSS_SF_PWR_CTRL] == $past(ld_slot_feat_i[1])))
		else $error("power controller bit not loaded");
	a_attn_ind_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ11
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=> (sf_word[PLSS_SF_ATTN_IND] == $past(ld_slot_feat_i[3])))
		else $error("attention indicator bit not loaded");
	a_pwr_ind_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ12
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=> (sf_word[PLSS_SF_PWR_IND] == $past(ld_slot_feat_i[4])))
		else $error("power indicator bit not loaded");
	a_surprise_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ13
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=> (sf_word[PLSS_SF_SURPRISE] == $past(ld_slot_feat_i[5])))
		else $error("surprise bit not loaded");
	a_slotnum_ld: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ17 RQ18
		(ce_i && strap_seen && ld_valid_i && DOWNSTREAM) |=>
		(slot_num == $past(ld_slot_feat_i[PLSS_SF_SLOTNUM_LSB +: 13]))) else $error("slot number not loaded");

	// capability bits only move on a loader write
	a_caps_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ18
		(ce_i && !ld_valid_i) |=> ($stable(slot_caps) && $stable(slot_num)))
		else $error("capability bits moved");

	// ----------------------------------------------------------------
	// power limit and message checks
	// ----------------------------------------------------------------

	// limit fields hold unless written or loaded
	a_plv_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ15
		(ce_i && !wr_plv && !ld_valid_i) |=> $stable(plv))
		else $error("limit value moved");
	a_pls_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ16
		(ce_i && !wr_pls && !ld_valid_i) |=> $stable(pls))
		else $error("limit scale moved");

	// the message carries the value just written
	a_msg_value: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ15 RQ19
		(ce_i && wr_plv && !ld_valid_i) |=> (pwr_msg_req_o && pwr_msg_value_o == $past(next_plv)))
		else $error("message value wrong");
	a_msg_scale: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ16 RQ19
		(ce_i && wr_pls && !ld_valid_i) |=> (pwr_msg_req_o && pwr_msg_scale_o == $past(next_pls)))
		else $error("message scale wrong");

	// no message without a slot word write
	a_msg_none: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ19
		(ce_i && !pwr_write) |=> !pwr_msg_req_o)
		else $error("message without write");

	// ----------------------------------------------------------------
	// interrupt and clock enable checks
	// ----------------------------------------------------------------

	// events set their sticky bits even against a clear
	a_irq_train: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && train_fail_i) |=> irq_status[PLSS_IRQ_TRAIN_ERR])
		else $error("training irq not set");
	a_irq_pwr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && pwr_write) |=> irq_status[PLSS_IRQ_PWR_MSG])
		else $error("power irq not set");

	// a clear with no event drops the written bits
	a_irq_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && wr_req && sel_clr && wb_sel_i[0] && irq_set == {PLSS_IRQ_N{1'b0}}) |=>
		((irq_status & $past(wb_dat_i[PLSS_IRQ_N-1:0])) == {PLSS_IRQ_N{1'b0}})) else $error("irq not cleared");

	// enable register takes lane zero
	a_irq_enable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(ce_i && wr_req && sel_en && wb_sel_i[0]) |=> (irq_enable == $past(wb_dat_i[PLSS_IRQ_N-1:0])))
		else $error("irq enable not written");

	// low clock enable freezes every register
	a_ce_freeze: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!ce_i |=> ($stable(train_err) && $stable(training) && $stable(plv) && $stable(pls) &&
		$stable(irq_status) && $stable(ack) && $stable(pwr_msg_req_o) && $stable(slot_clk)))
		else $error("state moved while frozen");

endmodule // plss_regs

// >>> tb/plss_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// bench for the link state and slot feature registers
// ----------------------------------------------------------------
module testbench
	import plss_pkg::*;
;
	logic mclk_i = 0, rst_b_i = 0, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, ld_slot_feat_i = 32'h0000_0000, wb_dat_o, r;
	logic [31:0] exp_q[$];
	logic wb_ack_o, pwr_msg_req_o, irq_o, train_fail_i = 0, train_active_i = 0, link_in_l0_i = 0, dl_active_i = 0;
	logic strap_slot_clk_i = 1, strap_hp_cap_i = 1, ld_valid_i = 0, ld_slot_clk_i = 0, ld_slot_clk_we_i = 0;
	logic [7:0] pwr_msg_value_o, plv;
	logic [1:0] pwr_msg_scale_o, pls;
	int fail_count = 0, check_count = 0, msg_count = 0, cyc_count = 0;

	plss_regs #(.DOWNSTREAM(1'b1)) dut_u (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.train_fail_i(train_fail_i), .train_active_i(train_active_i), .link_in_l0_i(link_in_l0_i),
		.dl_active_i(dl_active_i), .strap_slot_clk_i(strap_slot_clk_i), .strap_hp_cap_i(strap_hp_cap_i),
		.ld_valid_i(ld_valid_i), .ld_slot_feat_i(ld_slot_feat_i), .ld_slot_clk_i(ld_slot_clk_i),
		.ld_slot_clk_we_i(ld_slot_clk_we_i), .pwr_msg_req_o(pwr_msg_req_o),
		.pwr_msg_value_o(pwr_msg_value_o), .pwr_msg_scale_o(pwr_msg_scale_o), .irq_o(irq_o)
	);

	// free running 125 MHz clock
	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one classic cycle, entered just after a rising edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		@(posedge mclk_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge mclk_i);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] want);
		exp_q.push_back(want);
		bus(1'b0, adr, 4'hf, 32'h0000_0000);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		bus(1'b1, adr, sel, dat);
	endtask

	function automatic logic [31:0] ls(input logic dl, input logic tr, input logic clk, input logic err);
		return {2'b00, dl, clk, tr, err, PLSS_WIDTH_X1, PLSS_SPEED_2G5, 16'h0000};
	endfunction

	// watcher: read data against the oldest note, message pulses counted
	always @(negedge mclk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			check(wb_dat_o, exp_q.pop_front());
		end
		if (pwr_msg_req_o === 1'b1) begin
			msg_count++;
		end
	end

	// hang guard
	always @(posedge mclk_i) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 3000) begin
			fail_count++;
			finish_test;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(97257));
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rd(PLSS_OFF_LINK_STATE, ls(1'b0, 1'b0, 1'b1, 1'b0));
		rd(PLSS_OFF_SLOT_FEAT, 32'h0000_0040);
		rd(PLSS_OFF_OVERRIDE, 32'h0000_0000);
		plv = 8'($urandom);
		pls = 2'($urandom);
		// all ones into read-only fields must not stick
		wr(PLSS_OFF_SLOT_FEAT, 4'hf, {13'h1fff, 2'b11, pls, plv, 7'h7f});
		check({24'h0000_00, pwr_msg_value_o}, {24'h0000_00, plv});
		check({30'h0000_0000, pwr_msg_scale_o}, {30'h0000_0000, pls});
		wr(PLSS_OFF_SLOT_FEAT, 4'h1, 32'h0000_0000);
		wr(PLSS_OFF_LINK_STATE, 4'hf, 32'hffff_ffff);
		check(32'(msg_count), 32'h0000_0002);
		rd(PLSS_OFF_SLOT_FEAT, {15'h0000, pls, plv, 7'h40});
		rd(PLSS_OFF_LINK_STATE, ls(1'b0, 1'b0, 1'b1, 1'b0));
		rd(PLSS_OFF_IRQ_STATUS, 32'h0000_0004);
		wr(PLSS_OFF_IRQ_ENABLE, 4'hf, 32'h0000_0004);
		check({31'h0000_0000, irq_o}, 32'h0000_0001);
		wr(PLSS_OFF_IRQ_CLEAR, 4'hf, 32'h0000_0004);
		check({31'h0000_0000, irq_o}, 32'h0000_0000);
		// training fails while the data link comes up
		train_active_i <= 1'b1;
		train_fail_i <= 1'b1;
		@(posedge mclk_i);
		train_fail_i <= 1'b0;
		dl_active_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rd(PLSS_OFF_LINK_STATE, ls(1'b1, 1'b1, 1'b1, 1'b1));
		rd(PLSS_OFF_IRQ_STATUS, 32'h0000_0003);
		check({31'h0000_0000, irq_o}, 32'h0000_0000);
		// link reaches L0, loader overrides the slot clock bit
		train_active_i <= 1'b0;
		link_in_l0_i <= 1'b1;
		dl_active_i <= 1'b0;
		ld_slot_clk_we_i <= 1'b1;
		@(posedge mclk_i);
		ld_slot_clk_we_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rd(PLSS_OFF_LINK_STATE, ls(1'b0, 1'b0, 1'b0, 1'b0));
		// a training failure while frozen must not be seen
		link_in_l0_i <= 1'b0;
		ce_i <= 1'b0;
		train_fail_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		train_fail_i <= 1'b0;
		ce_i <= 1'b1;
		@(posedge mclk_i);
		rd(PLSS_OFF_LINK_STATE, ls(1'b0, 1'b0, 1'b0, 1'b0));
		r = $urandom & 32'hfff9_fffb;
		ld_slot_feat_i <= r;
		ld_valid_i <= 1'b1;
		@(posedge mclk_i);
		ld_valid_i <= 1'b0;
		@(posedge mclk_i);
		rd(PLSS_OFF_SLOT_FEAT, r);
		// second reset in mid-run: defaults and straps come back
		rst_b_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rd(PLSS_OFF_LINK_STATE, ls(1'b0, 1'b0, 1'b1, 1'b0));
		rd(PLSS_OFF_SLOT_FEAT, 32'h0000_0040);
		rd(PLSS_OFF_IRQ_STATUS, 32'h0000_0000);
		check({24'h0000_00, pwr_msg_value_o}, 32'h0000_0000);
		check({31'h0000_0000, irq_o}, 32'h0000_0000);
		finish_test;
	end
endmodule // testbench
